// ### hw/ffg_pkg.sv
// Constants, types and register map of the flash write guard host controller
//
// Contract
// - The host holds every strobe in a non-writing state while the supply is not yet good.
// - A write happens only with chip select and write strobe low and output strobe high, and the host drives exactly that.
// - The host reads erase_window_flag before and after each added sector erase and treats a high second read as rejected.
// - In data polling, after timeout_fail_flag is seen the host reads polled_data_bit once more before failing.
// - In toggle polling, after timeout_fail_flag is seen the host makes one more toggle comparison before failing.
package ffg_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_WC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int CYC_WC = (T_WC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_WP = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_ACC = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_LAT = 2;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_INT_STAT = 8'h14;
  localparam logic [7:0] REG_INT_MASK = 8'h18;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_ERASE_ADD_BIT = 3;

  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_REJECT_BIT = 3;

  localparam int INT_W = 3;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_FAIL_BIT = 1;
  localparam int INT_REJECT_BIT = 2;

  localparam int DQ_POLL_BIT = 7;
  localparam int DQ_TOGGLE_BIT = 6;
  localparam int DQ_TIMEOUT_BIT = 5;
  localparam int DQ_WINDOW_BIT = 3;
  localparam logic [DATA_W-1:0] RESET_CMD = 16'h00F0;

  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_DPOLL, OP_TPOLL} ffg_op_e;

  typedef struct packed {
    logic ceN;
    logic weN;
    logic oeN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dqOut;
    logic dqOeN;
  } ffg_pins_s;

  typedef struct packed {
    logic isWrite;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ffg_cyc_req_s;
endpackage

// ### hw/ffg_bus_cycle.sv
// Single flash bus cycle engine: one write or one read on the flash pins
`timescale 1ns/10ps
`default_nettype none
module ffg_bus_cycle #(
  parameter int WP_CYC = ffg_pkg::CYC_WP,
  parameter int WC_CYC = ffg_pkg::CYC_WC,
  parameter int ACC_CYC = ffg_pkg::CYC_ACC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic abort,
  input wire logic start,
  input wire ffg_pkg::ffg_cyc_req_s req,
  input wire logic [ffg_pkg::DATA_W-1:0] dqIn,
  output ffg_pkg::ffg_pins_s pins,
  output logic done,
  output logic [ffg_pkg::DATA_W-1:0] rdData
);
  import ffg_pkg::*;

  // Counts must fit the 8-bit cycle counter
  if (WP_CYC < 1 || WP_CYC > 256 || WC_CYC < WP_CYC + 2 || WC_CYC > WP_CYC + 257 || ACC_CYC < 1
      || ACC_CYC + SYNC_LAT > 256)
  begin : gBadTiming
    $error("ffg_bus_cycle: timing counts cannot be served");
  end

  typedef enum {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_READ} ffg_cyc_e;
  ffg_cyc_e state_ff;
  logic [7:0] cnt_ff;
  logic [DATA_W-1:0] dqMeta_ff;
  logic [DATA_W-1:0] dqSync_ff;

  // ****************************************
  // Pin input synchroniser
  // ****************************************
  always_ff @(posedge clk)
  begin
    dqMeta_ff <= dqIn;
    dqSync_ff <= dqMeta_ff;
  end

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    if (rst || abort)
    begin
      state_ff <= C_IDLE;
      cnt_ff <= 8'h00;
      pins.ceN <= 1'b1;
      pins.weN <= 1'b1;
      pins.oeN <= 1'b1;
      pins.dqOeN <= 1'b1;
      pins.addr <= '0;
      pins.dqOut <= '0;
      rdData <= '0;
    end
    else
    begin
      case (state_ff)
        C_IDLE:
        begin
          if (start)
          begin
            pins.addr <= req.addr;
            pins.dqOut <= req.data;
            pins.ceN <= 1'b0;
            if (req.isWrite)
            begin
              pins.dqOeN <= 1'b0;
              state_ff <= C_SETUP;
            end
            else
            begin
              pins.oeN <= 1'b0;
              cnt_ff <= 8'(ACC_CYC + SYNC_LAT - 1);
              state_ff <= C_READ;
            end
          end
        end
        C_SETUP:
        begin
          pins.weN <= 1'b0;
          cnt_ff <= 8'(WP_CYC - 1);
          state_ff <= C_STROBE;
        end
        C_STROBE:
        begin
          if (cnt_ff == 8'h00)
          begin
            pins.weN <= 1'b1;
            cnt_ff <= 8'(WC_CYC - WP_CYC - 2);
            state_ff <= C_HOLD;
          end
          else
            cnt_ff <= cnt_ff - 8'h01;
        end
        C_HOLD:
        begin
          if (cnt_ff == 8'h00)
          begin
            pins.ceN <= 1'b1;
            pins.dqOeN <= 1'b1;
            done <= 1'b1;
            state_ff <= C_IDLE;
          end
          else
            cnt_ff <= cnt_ff - 8'h01;
        end
        C_READ:
        begin
          if (cnt_ff == 8'h00)
          begin
            rdData <= dqSync_ff;
            pins.ceN <= 1'b1;
            pins.oeN <= 1'b1;
            done <= 1'b1;
            state_ff <= C_IDLE;
          end
          else
            cnt_ff <= cnt_ff - 8'h01;
        end
        default:
          state_ff <= C_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_write_combo: assert property (@(posedge clk) disable iff (rst)
    !pins.weN |-> (!pins.ceN && pins.oeN && !pins.dqOeN))
    else $error("write strobe low without chip select low and output strobe high");
  a_no_oe_we: assert property (@(posedge clk) disable iff (rst)
    !(pins.oeN == 1'b0 && pins.weN == 1'b0))
    else $error("output and write strobes low together");
  a_we_width: assert property (@(posedge clk) disable iff (rst || abort)
    $fell(pins.weN) |-> (!pins.weN)[*7] ##1 pins.weN)
    else $error("write strobe pulse width wrong");
  a_read_release: assert property (@(posedge clk) disable iff (rst)
    !pins.oeN |-> pins.dqOeN)
    else $error("data bus driven during a read");
endmodule
`default_nettype wire

// ### hw/ffg_host_ctrl.sv
// Host controller: flash write guard, command cycles and status polling
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ffg_host_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic irq,
  input wire logic supplyOk,
  input wire logic [ffg_pkg::DATA_W-1:0] dqIn,
  output ffg_pkg::ffg_pins_s flashPins
);
  import ffg_pkg::*;

  typedef enum {S_IDLE, S_PRE, S_WR, S_POST, S_RD, S_DPOLL, S_DRECHK, S_TPOLL, S_TRECHK, S_RSTCMD} ffg_state_e;

  ffg_state_e state_ff;
  ffg_op_e op_ff;
  logic eraseAdd_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] data_ff;
  logic [DATA_W-1:0] rdRes_ff;
  logic [DATA_W-1:0] prev_ff;
  logic tgFirst_ff;
  logic lastFail_ff;
  logic lastReject_ff;
  logic okMeta_ff;
  logic okSync_ff;
  logic [INT_W-1:0] intStat_ff;
  logic [INT_W-1:0] intMask_ff;
  logic [INT_W-1:0] evt_ff;
  logic cycStart_ff;
  logic cycPend_ff;
  ffg_cyc_req_s cycReq_ff;
  logic cycDone;
  logic [DATA_W-1:0] cycData;
  logic startReq;

  function automatic logic dqBit(input logic [DATA_W-1:0] v, input int pos);
    dqBit = v[pos];
  endfunction

  // ****************************************
  // Supply good synchroniser
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      okMeta_ff <= 1'b0;
      okSync_ff <= 1'b0;
    end
    else
    begin
      okMeta_ff <= supplyOk;
      okSync_ff <= okMeta_ff;
    end
  end

  ffg_bus_cycle u_cycle (
    .clk(clk),
    .rst(rst),
    .abort(!okSync_ff),
    .start(cycStart_ff),
    .req(cycReq_ff),
    .dqIn(dqIn),
    .pins(flashPins),
    .done(cycDone),
    .rdData(cycData)
  );

  assign startReq = regWr && regAddr == REG_CTRL && regWdata[CTRL_START_BIT];

  // ****************************************
  // Operation sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    cycStart_ff <= 1'b0;
    evt_ff <= '0;
    if (rst || !okSync_ff)
    begin
      state_ff <= S_IDLE;
      cycPend_ff <= 1'b0;
      cycReq_ff <= '0;
      tgFirst_ff <= 1'b0;
      prev_ff <= '0;
      if (rst)
      begin
        op_ff <= OP_READ;
        eraseAdd_ff <= 1'b0;
        addr_ff <= '0;
        data_ff <= '0;
        rdRes_ff <= '0;
        lastFail_ff <= 1'b0;
        lastReject_ff <= 1'b0;
      end
      else if (startReq)
      begin
        lastReject_ff <= 1'b1;
        evt_ff[INT_REJECT_BIT] <= 1'b1;
      end
    end
    else if (state_ff == S_IDLE)
    begin
      if (regWr && regAddr == REG_ADDR)
        addr_ff <= regWdata[ADDR_W-1:0];
      if (regWr && regAddr == REG_DATA)
        data_ff <= regWdata[DATA_W-1:0];
      if (startReq)
      begin
        op_ff <= ffg_op_e'(regWdata[CTRL_OP_LSB +: 2]);
        eraseAdd_ff <= regWdata[CTRL_ERASE_ADD_BIT];
        lastFail_ff <= 1'b0;
        lastReject_ff <= 1'b0;
        tgFirst_ff <= 1'b1;
        case (ffg_op_e'(regWdata[CTRL_OP_LSB +: 2]))
          OP_WRITE: state_ff <= regWdata[CTRL_ERASE_ADD_BIT] ? S_PRE : S_WR;
          OP_READ: state_ff <= S_RD;
          OP_DPOLL: state_ff <= S_DPOLL;
          OP_TPOLL: state_ff <= S_TPOLL;
          default: state_ff <= S_IDLE;
        endcase
      end
    end
    else if (!cycPend_ff)
    begin
      cycPend_ff <= 1'b1;
      cycStart_ff <= 1'b1;
      cycReq_ff.isWrite <= (state_ff == S_WR || state_ff == S_RSTCMD);
      cycReq_ff.addr <= addr_ff;
      cycReq_ff.data <= (state_ff == S_RSTCMD) ? RESET_CMD : data_ff;
    end
    else if (cycDone)
    begin
      cycPend_ff <= 1'b0;
      rdRes_ff <= cycData;
      case (state_ff)
        S_PRE:
        begin
          if (dqBit(cycData, DQ_WINDOW_BIT))
          begin
            lastReject_ff <= 1'b1;
            evt_ff[INT_REJECT_BIT] <= 1'b1;
            state_ff <= S_IDLE;
          end
          else
            state_ff <= S_WR;
        end
        S_WR:
        begin
          rdRes_ff <= rdRes_ff;
          if (eraseAdd_ff)
            state_ff <= S_POST;
          else
          begin
            evt_ff[INT_DONE_BIT] <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_POST:
        begin
          if (dqBit(cycData, DQ_WINDOW_BIT))
          begin
            lastReject_ff <= 1'b1;
            evt_ff[INT_REJECT_BIT] <= 1'b1;
          end
          else
            evt_ff[INT_DONE_BIT] <= 1'b1;
          state_ff <= S_IDLE;
        end
        S_DPOLL, S_DRECHK:
        begin
          if (dqBit(cycData, DQ_POLL_BIT) == dqBit(data_ff, DQ_POLL_BIT))
          begin
            evt_ff[INT_DONE_BIT] <= 1'b1;
            state_ff <= S_IDLE;
          end
          else if (state_ff == S_DRECHK)
            state_ff <= S_RSTCMD;
          else if (dqBit(cycData, DQ_TIMEOUT_BIT))
            state_ff <= S_DRECHK;
        end
        S_TPOLL, S_TRECHK:
        begin
          prev_ff <= cycData;
          tgFirst_ff <= 1'b0;
          if (!tgFirst_ff && dqBit(cycData, DQ_TOGGLE_BIT) == dqBit(prev_ff, DQ_TOGGLE_BIT))
          begin
            evt_ff[INT_DONE_BIT] <= 1'b1;
            state_ff <= S_IDLE;
          end
          else if (state_ff == S_TRECHK)
            state_ff <= S_RSTCMD;
          else if (!tgFirst_ff && dqBit(cycData, DQ_TIMEOUT_BIT))
            state_ff <= S_TRECHK;
        end
        S_RSTCMD:
        begin
          rdRes_ff <= rdRes_ff;
          lastFail_ff <= 1'b1;
          evt_ff[INT_FAIL_BIT] <= 1'b1;
          state_ff <= S_IDLE;
        end
        default:
        begin
          evt_ff[INT_DONE_BIT] <= 1'b1;
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      intStat_ff <= '0;
      intMask_ff <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (regRd && regAddr == REG_INT_STAT)
        intStat_ff <= evt_ff;
      else
        intStat_ff <= intStat_ff | evt_ff;
      if (regWr && regAddr == REG_INT_MASK)
        intMask_ff <= regWdata[INT_W-1:0];
      irq <= |(intStat_ff & intMask_ff);
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      regRdata <= '0;
    else if (regRd)
    begin
      case (regAddr)
        REG_CTRL: regRdata <= 32'({eraseAdd_ff, op_ff, 1'b0});
        REG_ADDR: regRdata <= 32'(addr_ff);
        REG_DATA: regRdata <= 32'(data_ff);
        REG_RDATA: regRdata <= 32'(rdRes_ff);
        REG_STATUS: regRdata <= 32'({lastReject_ff, lastFail_ff, !okSync_ff, state_ff != S_IDLE});
        REG_INT_STAT: regRdata <= 32'(intStat_ff);
        REG_INT_MASK: regRdata <= 32'(intMask_ff);
        default: regRdata <= 32'h0000_0000;
      endcase
    end
    else
      regRdata <= 32'h0000_0000;
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence dpollTimeoutSeen;
    state_ff == S_DPOLL && cycDone && dqBit(cycData, DQ_POLL_BIT) != dqBit(data_ff, DQ_POLL_BIT)
      && dqBit(cycData, DQ_TIMEOUT_BIT);
  endsequence
  sequence recheckRead;
    state_ff == S_DRECHK && cycStart_ff && !cycReq_ff.isWrite;
  endsequence

  a_lock_strobes: assert property (@(posedge clk) disable iff (rst)
    !okSync_ff |=> flashPins.weN && flashPins.ceN)
    else $error("strobes active while supply not good");
  a_dpoll_recheck: assert property (@(posedge clk) disable iff (rst || !okSync_ff)
    dpollTimeoutSeen |=> !lastFail_ff ##1 recheckRead)
    else $error("data poll failed without a recheck read");
  a_fail_resets: assert property (@(posedge clk) disable iff (rst || !okSync_ff)
    $rose(lastFail_ff) |-> $past(state_ff) == S_RSTCMD && $past(cycReq_ff.data) == RESET_CMD)
    else $error("failure reported without reset command");
  a_window_reject: assert property (@(posedge clk) disable iff (rst || !okSync_ff)
    (state_ff == S_POST && cycDone && dqBit(cycData, DQ_WINDOW_BIT))
      |=> lastReject_ff ##2 (irq || !intMask_ff[INT_REJECT_BIT]))
    else $error("late erase window not reported as rejected");
  a_trecheck_cmp: assert property (@(posedge clk) disable iff (rst || !okSync_ff)
    (state_ff == S_TRECHK && cycDone && dqBit(cycData, DQ_TOGGLE_BIT) == dqBit(prev_ff, DQ_TOGGLE_BIT))
      |=> state_ff == S_IDLE && !lastFail_ff)
    else $error("toggle recheck equal but operation failed");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    |(intStat_ff & intMask_ff) |=> irq)
    else $error("interrupt not raised for unmasked status");
endmodule
`default_nettype wire

// ### verif/ffg_flash_model.sv
// Behavioural model of the parallel flash seen by the host controller
`timescale 1ns/10ps
`default_nettype none
module ffg_flash_model (
  input wire ffg_pkg::ffg_pins_s pins,
  input wire logic supplyOk,
  input wire logic [ffg_pkg::DATA_W-1:0] dqWire,
  input wire logic setBusy,
  input wire logic [15:0] busyN,
  input wire logic failIn,
  input wire logic windowIn,
  input wire logic [ffg_pkg::DATA_W-1:0] cellData,
  output logic [ffg_pkg::DATA_W-1:0] dqDrv,
  output logic drvOn,
  output logic [15:0] wrCount,
  output logic [ffg_pkg::DATA_W-1:0] lastWr
);
  import ffg_pkg::*;
  int busy = 0;
  logic tog = 1'b0;
  logic armed = 1'b0;
  logic [DATA_W-1:0] rdVal = '0;
  initial
  begin
    wrCount = '0;
    lastWr = '0;
  end
  // Supply edge drops to read mode
  always @(supplyOk)
  begin
    busy = 0;
    tog = 1'b0;
    armed = supplyOk && !(!pins.ceN && !pins.weN && pins.oeN);
  end
  always @(posedge setBusy)
  begin
    busy = int'(busyN);
    tog = 1'b0;
  end
  always @(posedge pins.weN)
  begin
    if (armed && supplyOk && !pins.ceN && pins.oeN)
    begin
      wrCount = wrCount + 16'h0001;
      lastWr = dqWire;
      if (dqWire == RESET_CMD)
        busy = 0;
    end
    armed = 1'b1;
  end
  always @(negedge pins.oeN)
  begin
    if (busy > 0)
    begin
      rdVal = ~cellData;
      rdVal[DQ_TOGGLE_BIT] = tog;
      rdVal[DQ_TIMEOUT_BIT] = failIn;
      rdVal[DQ_WINDOW_BIT] = windowIn;
      tog = ~tog;
      busy = busy - 1;
    end
    else
      rdVal = cellData;
  end
  assign drvOn = supplyOk && !pins.ceN && !pins.oeN;
  assign dqDrv = rdVal;
endmodule
`default_nettype wire

// ### verif/test_ffg_host_ctrl.sv
// Self-checking testbench of the flash write guard host controller
`timescale 1ns/10ps
`default_nettype none
module test_ffg_host_ctrl;
  import ffg_pkg::*;
  localparam logic [DATA_W-1:0] CELL = 16'h00C5;
  logic clk, rst, regWr, regRd, supplyOk, setBusy, failIn, windowIn, irq, drvOn;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, st;
  logic [DATA_W-1:0] dqWire, dqDrv, lastWr, idleDq;
  logic [15:0] busyN, wrCount, nWr;
  ffg_pins_s pins;
  int fails = 0;
  int checked = 0;
  int lowCnt = 0;
  ffg_host_ctrl u_ffg_host_ctrl (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .supplyOk(supplyOk),
    .dqIn(dqWire), .flashPins(pins));
  ffg_flash_model u_ffg_flash_model (.pins(pins), .supplyOk(supplyOk), .dqWire(dqWire),
    .setBusy(setBusy), .busyN(busyN), .failIn(failIn), .windowIn(windowIn), .cellData(CELL),
    .dqDrv(dqDrv), .drvOn(drvOn), .wrCount(wrCount), .lastWr(lastWr));
  // Undriven bus changes every cycle
  always @(posedge clk)
    idleDq <= ~idleDq;
  assign dqWire = !pins.dqOeN ? pins.dqOut : (drvOn ? dqDrv : idleDq);
  // ****
  // Helpers
  // ****
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic regW(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic regR(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    regR(REG_STATUS, st);
    while (st[ST_BUSY_BIT] !== 1'b0 && n < 300)
    begin
      regR(REG_STATUS, st);
      n++;
    end
    chk("idle wait", {31'h0, st[ST_BUSY_BIT]}, 32'h0);
  endtask
  task automatic runOp(input logic [1:0] op, input logic ea);
    regW(REG_CTRL, {28'h0, ea, op, 1'b1});
    waitIdle();
  endtask
  task automatic setFlash(input logic [15:0] n, input logic f, input logic w);
    busyN = n;
    failIn = f;
    windowIn = w;
    setBusy = 1'b1;
    #1 setBusy = 1'b0;
    nWr = wrCount;
  endtask
  task automatic pollCase(input logic [1:0] op, input logic [15:0] n, input logic expFail);
    setFlash(n, 1'b1, 1'b0);
    runOp(op, 1'b0);
    chk("fail status", {31'h0, st[ST_FAIL_BIT]}, {31'h0, expFail});
    chk("reset count", {16'h0, wrCount}, {16'h0, nWr + {15'h0, expFail}});
    if (expFail)
      chk("reset cmd", {16'h0, lastWr}, {16'h0, RESET_CMD});
    regR(REG_INT_STAT, st);
    chk("fail event", {31'h0, st[INT_FAIL_BIT]}, {31'h0, expFail});
  endtask
  // ****
  // Scenarios
  // ****
  task automatic testLockout();
    regR(REG_INT_MASK, st);
    chk("mask reset", st, 32'h0);
    regR(8'h1C, st);
    chk("unmapped read", st, 32'h0);
    regW(REG_DATA, {16'h0, CELL});
    runOp(OP_WRITE, 1'b0);
    chk("lockout status", st, 32'h0000_000A);
    chk("lockout writes", {16'h0, wrCount}, 32'h0);
    regR(REG_INT_STAT, st);
    chk("reject event", st, 32'h0000_0004);
    regR(REG_INT_STAT, st);
    chk("event cleared", st, 32'h0);
    regR(REG_DATA, st);
    chk("data refused", st, 32'h0);
    supplyOk <= 1'b1;
    repeat (4) @(posedge clk);
    $display("Test lockout done");
  endtask
  task automatic testWrite();
    regW(REG_INT_MASK, 32'h1);
    regW(REG_DATA, {16'h0, CELL});
    nWr = wrCount;
    runOp(OP_WRITE, 1'b0);
    chk("write count", {16'h0, wrCount}, {16'h0, nWr + 16'h0001});
    chk("write data", {16'h0, lastWr}, {16'h0, CELL});
    @(posedge clk);
    #1;
    chk("irq done", {31'h0, irq}, 32'h1);
    regR(REG_INT_STAT, st);
    chk("done event", st, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("irq clear", {31'h0, irq}, 32'h0);
    regW(REG_INT_MASK, 32'h0);
    runOp(OP_READ, 1'b0);
    regR(REG_RDATA, st);
    chk("read data", st, {16'h0, CELL});
    $display("Test write done");
  endtask
  task automatic testDataPoll();
    pollCase(OP_DPOLL, 16'h0001, 1'b0);
    pollCase(OP_DPOLL, 16'h03E8, 1'b1);
    $display("Test data poll done");
  endtask
  task automatic testTogglePoll();
    pollCase(OP_TPOLL, 16'h0002, 1'b0);
    pollCase(OP_TPOLL, 16'h03E8, 1'b1);
    $display("Test toggle poll done");
  endtask
  task automatic testEraseAdd();
    setFlash(16'h0000, 1'b0, 1'b0);
    runOp(OP_WRITE, 1'b1);
    chk("erase add taken", {16'h0, wrCount}, {16'h0, nWr + 16'h0001});
    regR(REG_INT_STAT, st);
    chk("no reject", {31'h0, st[INT_REJECT_BIT]}, 32'h0);
    setFlash(16'h03E8, 1'b0, 1'b1);
    runOp(OP_WRITE, 1'b1);
    chk("erase add held", {16'h0, wrCount}, {16'h0, nWr});
    regR(REG_INT_STAT, st);
    chk("reject event", {31'h0, st[INT_REJECT_BIT]}, 32'h1);
    // Window closes only after the added erase is written
    regW(REG_INT_MASK, 32'h4);
    setFlash(16'h03E8, 1'b0, 1'b0);
    regW(REG_CTRL, {28'h0, 1'b1, OP_WRITE, 1'b1});
    @(wrCount);
    windowIn = 1'b1;
    waitIdle();
    chk("late window write", {16'h0, wrCount}, {16'h0, nWr + 16'h0001});
    chk("late reject", {31'h0, st[ST_REJECT_BIT]}, 32'h1);
    @(posedge clk);
    #1;
    chk("irq reject", {31'h0, irq}, 32'h1);
    regR(REG_INT_STAT, st);
    chk("late reject event", {31'h0, st[INT_REJECT_BIT]}, 32'h1);
    regW(REG_INT_MASK, 32'h0);
    setFlash(16'h0000, 1'b0, 1'b0);
    $display("Test erase add done");
  endtask
  task automatic testAbort();
    nWr = wrCount;
    regW(REG_CTRL, {28'h0, 1'b0, OP_WRITE, 1'b1});
    repeat (4) @(posedge clk);
    supplyOk <= 1'b0;
    repeat (12) @(posedge clk);
    chk("aborted write", {16'h0, wrCount}, {16'h0, nWr});
    waitIdle();
    regR(REG_INT_STAT, st);
    chk("no abort event", st, 32'h0);
    supplyOk <= 1'b1;
    repeat (4) @(posedge clk);
    $display("Test abort done");
  endtask
  // Strobe watch: lockout idle and exact write combination
  always @(posedge clk)
  begin
    lowCnt <= supplyOk ? 0 : lowCnt + 1;
    if (lowCnt > 3)
      chk("lockout strobes", {30'h0, pins.ceN, pins.weN}, 32'h3);
    if (!rst && !pins.weN)
      chk("write combination", {30'h0, pins.ceN, pins.oeN}, 32'h1);
  end
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {rst, regWr, regRd, supplyOk, setBusy, failIn, windowIn} = 7'b1000000;
    regAddr = '0;
    regWdata = '0;
    busyN = '0;
    idleDq = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    testLockout();
    testWrite();
    testDataPoll();
    testTogglePoll();
    testEraseAdd();
    testAbort();
    report_and_stop();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
